// ### adc_cmp_pkg.sv
package adc_cmp_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CTRL_OFFSET   = 8'h80;
  localparam logic [7:0] CONFIG_OFFSET = 8'h9A;
  localparam logic [7:0] RESULT_OFFSET = 8'h9F;

  // Control register fields
  localparam int CTRL_CMP_RESULT_BIT = 7;
  localparam int CTRL_CMP_CHANGE_BIT = 6;
  localparam int CTRL_DONE_BIT       = 5;
  localparam int CTRL_START_BIT      = 4;
  localparam int CTRL_INV_SEL_BIT    = 3;
  localparam int CTRL_CHAN_HIGH_BIT  = 1;
  localparam int CTRL_CHAN_LOW_BIT   = 0;

  // Configuration register fields
  localparam int CFG_ADC_POWER_BIT  = 3;
  localparam int CFG_CMP_POWER_BIT  = 2;
  localparam int CFG_CLK_SELECT_BIT = 0;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Conversion timing in oscillator cycles
  localparam int FAST_CONV_CYCLES = 96;
  localparam int SLOW_CONV_CYCLES = 384;
  localparam int CONV_CNT_W       = 9;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_DONE
  } conv_state_t;

endpackage

// ### analog_input_mux.sv
module analog_input_mux
  import adc_cmp_pkg::*;
(
  input  wire logic [7:0] ain0_in,      // Analog input 0 sample
  input  wire logic [7:0] ain1_in,      // Analog input 1 sample
  input  wire logic [7:0] ain2_in,      // Analog input 2 sample
  input  wire logic [7:0] ain3_in,      // Analog input 3 sample
  input  wire logic [1:0] chan_sel_in,  // Positive channel select
  input  wire logic       inv_sel_in,   // Inverted input select
  output logic      [7:0] pos_out,      // Positive / converter input
  output logic      [7:0] neg_out       // Comparator inverted input
);

  always_comb begin
    case (chan_sel_in)
      2'h0:    pos_out = ain0_in;
      2'h1:    pos_out = ain1_in;
      2'h2:    pos_out = ain2_in;
      default: pos_out = ain3_in;
    endcase
  end

  assign neg_out = inv_sel_in ? ain3_in : ain1_in;

endmodule

// ### conv_timer.sv
module conv_timer
  import adc_cmp_pkg::*;
(
  input  wire logic clk_in,     // Oscillator clock
  input  wire logic rst_in,     // Synchronous reset
  input  wire logic start_in,   // Begin a timed conversion
  input  wire logic abort_in,   // Stop counting
  input  wire logic fast_in,    // Fast conversion clock chosen
  output logic      done_out    // One-cycle pulse at the end
);

  localparam logic [CONV_CNT_W-1:0] FAST_LAST = CONV_CNT_W'(FAST_CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] SLOW_LAST = CONV_CNT_W'(SLOW_CONV_CYCLES - 1);

  logic [CONV_CNT_W-1:0] count_q;
  logic [CONV_CNT_W-1:0] last_q;
  logic                  busy_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || abort_in) begin
      busy_q   <= 1'b0;
      count_q  <= '0;
      last_q   <= FAST_LAST;
      done_out <= 1'b0;
    end else if (start_in && !busy_q) begin
      busy_q   <= 1'b1;
      count_q  <= '0;
      last_q   <= fast_in ? FAST_LAST : SLOW_LAST;
      done_out <= 1'b0;
    end else if (busy_q) begin
      count_q  <= count_q + 1'b1;
      done_out <= (count_q == last_q - 1'b1);
      busy_q   <= (count_q != last_q - 1'b1);
    end else begin
      done_out <= 1'b0;
    end
  end

endmodule

// ### adc_comparator_control.sv
// Contract
// - Config bit 3 powers the converter; 0 sleeps it; resets to 0.
// - Config bit 2 powers the comparator; 0 sleeps it; resets to 0.
// - Config bit 0 high picks fast clock: 96 oscillator cycles per conversion.
// - Result register holds latest 8-bit result, read-only, undefined after reset.
// - Setting start bit performs one conversion on the selected channel.
// - On completion start clears, done flag sets, result becomes readable.
// - Result is input voltage in 255 equal steps of supply.
// - A new start begins the next conversion; no automatic repeat.
// - Live comparator result bit is readable at any time.
// - Comparator change flag sets whenever the comparator output changes; code skips the result change at comparator power-on and power-off.
// - Channel code 00..11 selects inputs 0..3, also comparator positive.
// - Inverted input is input 1 when bit is 0, input 3 when 1.
// - Comparator result is 1 when positive exceeds inverted, else 0.
// - Done and change flags set by hardware, cleared by writing 0.
//
// Our own choices: the register offsets and the address-and-strobe port.
module adc_comparator_control
  import adc_cmp_pkg::*;
(
  input  wire logic       clk_in,         // Oscillator clock
  input  wire logic       rst_in,         // Synchronous reset, active high
  input  wire logic [7:0] addr_in,        // Register address
  input  wire logic [7:0] wdata_in,       // Write data
  input  wire logic       wr_in,          // Write strobe
  input  wire logic       rd_in,          // Read strobe
  output logic      [7:0] rdata_out,      // Read data, cycle after strobe
  input  wire logic [7:0] ain0_in,        // Digitised level of input 0
  input  wire logic [7:0] ain1_in,        // Digitised level of input 1
  input  wire logic [7:0] ain2_in,        // Digitised level of input 2
  input  wire logic [7:0] ain3_in,        // Digitised level of input 3
  output logic            adc_power_out,  // Converter powered
  output logic            cmp_power_out,  // Comparator powered
  output logic            busy_out        // Conversion in progress
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  logic       adc_power_q;
  logic       cmp_power_q;
  logic       clk_select_q;
  logic       start_q;
  logic       done_flag_q;
  logic       change_flag_q;
  logic       inv_select_q;
  logic       channel_select_high;
  logic       channel_select_low;
  logic [7:0] result_q;
  logic       cmp_result_q;
  logic       cmp_valid_q;
  conv_state_t state_q;

  logic [7:0] pos_level;
  logic [7:0] neg_level;
  logic       conv_done;
  logic       conv_go;
  logic       ctrl_wr;
  logic       cfg_wr;
  logic       cmp_raw;
  logic       cmp_edge;

  assign ctrl_wr = wr_in && (addr_in == CTRL_OFFSET);
  assign cfg_wr  = wr_in && (addr_in == CONFIG_OFFSET);

  ////////////////////////////////////////////////////////////////////////
  // Input routing and conversion timer

  analog_input_mux u_mux (
    .ain0_in     (ain0_in),
    .ain1_in     (ain1_in),
    .ain2_in     (ain2_in),
    .ain3_in     (ain3_in),
    .chan_sel_in ({channel_select_high, channel_select_low}),
    .inv_sel_in  (inv_select_q),
    .pos_out     (pos_level),
    .neg_out     (neg_level)
  );

  assign conv_go = (state_q == CONV_IDLE) && start_q && adc_power_q;

  conv_timer u_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (conv_go),
    .abort_in (!adc_power_q),
    .fast_in  (clk_select_q),
    .done_out (conv_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration register

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_power_q  <= CONFIG_RESET[CFG_ADC_POWER_BIT];
      cmp_power_q  <= CONFIG_RESET[CFG_CMP_POWER_BIT];
      clk_select_q <= CONFIG_RESET[CFG_CLK_SELECT_BIT];
    end else if (cfg_wr) begin
      adc_power_q  <= wdata_in[CFG_ADC_POWER_BIT];
      cmp_power_q  <= wdata_in[CFG_CMP_POWER_BIT];
      clk_select_q <= wdata_in[CFG_CLK_SELECT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register selects

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inv_select_q        <= CTRL_RESET[CTRL_INV_SEL_BIT];
      channel_select_high <= CTRL_RESET[CTRL_CHAN_HIGH_BIT];
      channel_select_low  <= CTRL_RESET[CTRL_CHAN_LOW_BIT];
    end else if (ctrl_wr) begin
      inv_select_q        <= wdata_in[CTRL_INV_SEL_BIT];
      channel_select_high <= wdata_in[CTRL_CHAN_HIGH_BIT];
      channel_select_low  <= wdata_in[CTRL_CHAN_LOW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= CONV_IDLE;
    end else if (!adc_power_q) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_IDLE: begin
          if (conv_go) begin
            state_q <= CONV_RUN;
          end
        end
        CONV_RUN: begin
          if (conv_done) begin
            state_q <= CONV_DONE;
          end
        end
        CONV_DONE: state_q <= CONV_IDLE;
        default:   state_q <= CONV_IDLE;
      endcase
    end
  end

  // Start bit: firmware sets it, completion clears it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_q <= CTRL_RESET[CTRL_START_BIT];
    end else if (conv_done) begin
      start_q <= 1'b0;
    end else if (ctrl_wr) begin
      start_q <= wdata_in[CTRL_START_BIT];
    end
  end

  // Result sampled when the conversion ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_q <= RESULT_RESET;
    end else if (conv_done) begin
      result_q <= pos_level;
    end
  end

  // Done flag: set beats a write of 0 in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_flag_q <= CTRL_RESET[CTRL_DONE_BIT];
    end else if (conv_done) begin
      done_flag_q <= 1'b1;
    end else if (ctrl_wr && !wdata_in[CTRL_DONE_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator

  assign cmp_raw  = pos_level > neg_level;
  assign cmp_edge = cmp_power_q && cmp_valid_q && (cmp_raw != cmp_result_q);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmp_result_q <= 1'b0;
      cmp_valid_q  <= 1'b0;
    end else if (cmp_power_q) begin
      cmp_result_q <= cmp_raw;
      cmp_valid_q  <= 1'b1;
    end else begin
      cmp_result_q <= 1'b0;
      cmp_valid_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      change_flag_q <= CTRL_RESET[CTRL_CMP_CHANGE_BIT];
    end else if (cmp_edge) begin
      change_flag_q <= 1'b1;
    end else if (ctrl_wr && !wdata_in[CTRL_CMP_CHANGE_BIT]) begin
      change_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port and status outputs

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        CTRL_OFFSET: rdata_out <= {cmp_result_q, change_flag_q, done_flag_q, start_q,
                                   inv_select_q, 1'b0, channel_select_high,
                                   channel_select_low};
        CONFIG_OFFSET: rdata_out <= {4'h0, adc_power_q, cmp_power_q, 1'b0, clk_select_q};
        RESULT_OFFSET: rdata_out <= result_q;
        default:       rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_power_out <= 1'b0;
      cmp_power_out <= 1'b0;
      busy_out      <= 1'b0;
    end else begin
      adc_power_out <= adc_power_q;
      cmp_power_out <= cmp_power_q;
      busy_out      <= (state_q == CONV_RUN);
    end
  end

endmodule

// ### adc_cmp_assertions.sv
module adc_cmp_assertions
  import adc_cmp_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [7:0] ain0_in,
  input wire logic [7:0] ain1_in,
  input wire logic [7:0] ain2_in,
  input wire logic [7:0] ain3_in,
  input wire logic       adc_power_out,
  input wire logic       cmp_power_out,
  input wire logic       busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [8:0] run_q;
  wire        cfg_wr = wr_in && addr_in == CONFIG_OFFSET;
  wire        go_wr  = wr_in && addr_in == CTRL_OFFSET && wdata_in[CTRL_START_BIT];
  wire        mapped = addr_in inside {CTRL_OFFSET, CONFIG_OFFSET, RESULT_OFFSET};
  // Length of the current busy run
  always_ff @(posedge clk_in) begin
    if (rst_in || !busy_out) run_q <= 9'h000;
    else run_q <= run_q + 9'h001;
  end
  a_adc_power: assert property (cfg_wr ##1 !cfg_wr |=>
    adc_power_out == $past(wdata_in[CFG_ADC_POWER_BIT], 2)) else $error("adc power wrong");
  a_cmp_power: assert property (cfg_wr ##1 !cfg_wr |=>
    cmp_power_out == $past(wdata_in[CFG_CMP_POWER_BIT], 2)) else $error("cmp power wrong");
  a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read");
  a_unmapped_read: assert property (rd_in && !mapped |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_conv_bound: assert property (busy_out |-> run_q <= 9'h180)
    else $error("conversion too long");
  a_start_runs: assert property (go_wr && adc_power_out && !busy_out |-> ##[1:3] busy_out)
    else $error("start ignored");
  a_no_repeat: assert property ($fell(busy_out) ##0 !wr_in [*4] |-> !busy_out)
    else $error("conversion repeated");
  a_sleep_idle: assert property (!adc_power_out [*3] |-> !busy_out)
    else $error("busy while unpowered");
  a_reset_quiet: assert property ($fell(rst_in) |->
    !adc_power_out && !cmp_power_out && !busy_out) else $error("outputs not idle");
  cover property ($fell(busy_out));
  cover property (rd_in && addr_in == RESULT_OFFSET);
  cover property ($rose(cmp_power_out));
endmodule

// ### analog_source_model.sv
module analog_source_model (
  input  wire logic        clk_in,    // Oscillator clock
  input  wire logic [31:0] level_in,  // Wanted levels, input 3 on top
  output logic      [7:0]  ain0_out,  // Level at input 0
  output logic      [7:0]  ain1_out,  // Level at input 1
  output logic      [7:0]  ain2_out,  // Level at input 2
  output logic      [7:0]  ain3_out   // Level at input 3
);
  // Floating input pins, no pulls; a new level settles in one cycle
  always_ff @(posedge clk_in) begin
    {ain3_out, ain2_out, ain1_out, ain0_out} <= level_in;
  end
endmodule

// ### tb.sv
module tb import adc_cmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_in, wr_in, rd_in, adc_power_out, cmp_power_out, busy_out;
  logic [7:0]  addr_in, wdata_in, rdata_out, ain0, ain1, ain2, ain3;
  logic [31:0] level_q;
  int          miscompares, checks_done;
  analog_source_model analog_source_model_inst (.clk_in(clk_in), .level_in(level_q),
    .ain0_out(ain0), .ain1_out(ain1), .ain2_out(ain2), .ain3_out(ain3));
  adc_comparator_control adc_comparator_control_inst (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ain0_in(ain0), .ain1_in(ain1), .ain2_in(ain2), .ain3_in(ain3),
    .adc_power_out(adc_power_out), .cmp_power_out(cmp_power_out), .busy_out(busy_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    check({8'h00, rdata_out}, {8'h00, e});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(CTRL_OFFSET, CTRL_RESET);
    rchk(CONFIG_OFFSET, CONFIG_RESET);
    rchk(RESULT_OFFSET, RESULT_RESET);
    rchk(8'h81, 8'h00);
  endtask
  task automatic t_config;
    wr(CONFIG_OFFSET, 8'hFF);
    rchk(CONFIG_OFFSET, 8'h0D);
    check({14'h0, adc_power_out, cmp_power_out}, 16'h0003);
    wr(RESULT_OFFSET, 8'h5A);
    rchk(RESULT_OFFSET, RESULT_RESET);
  endtask
  task automatic t_conv(input logic fast, input logic [1:0] ch, input int cycles);
    int n;
    n = 0;
    wr(CONFIG_OFFSET, 8'h08 | {7'h00, fast});
    wr(CTRL_OFFSET, 8'h10 | {6'h00, ch});
    for (int i = 0; i < 500; i++) begin
      @(negedge clk_in);
      if (busy_out === 1'b1) n++;
    end
    check(16'(n), 16'(cycles));
    rchk(CTRL_OFFSET, 8'h20 | {6'h00, ch});
    rchk(RESULT_OFFSET, level_q[8*ch +: 8]);
    wr(CTRL_OFFSET, {6'h00, ch});
  endtask
  task automatic t_sleep;
    wr(CONFIG_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h10);
    repeat (20) @(posedge clk_in);
    check({15'h0, busy_out}, 16'h0000);
    rchk(CTRL_OFFSET, 8'h10);
    wr(CONFIG_OFFSET, 8'h09);
    repeat (120) @(posedge clk_in);
    rchk(CTRL_OFFSET, 8'h20);
    wr(CTRL_OFFSET, 8'h20);
    rchk(CTRL_OFFSET, 8'h20);
    wr(CTRL_OFFSET, 8'h00);
    rchk(CTRL_OFFSET, 8'h00);
  endtask
  task automatic cw(input logic [7:0] d, input logic [7:0] e);
    wr(CTRL_OFFSET, d);
    repeat (3) @(posedge clk_in);
    rchk(CTRL_OFFSET, e);
  endtask
  task automatic t_cmp;
    wr(CONFIG_OFFSET, 8'h04);
    repeat (3) @(posedge clk_in);
    cw(8'h00, 8'h80);
    cw(8'h0B, 8'h4B);
    cw(8'h0B, 8'h0B);
    cw(8'h02, 8'hC2);
    cw(8'h49, 8'hC9);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #(8 * 20000);
    miscompares++;
    print_verdict();
  end
  initial begin
    {rst_in, wr_in, rd_in, addr_in, wdata_in} = {3'b100, 16'h0000};
    level_q = 32'h00FF3CA5;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_config();
    for (int c = 0; c < 4; c++) t_conv(1'b1, 2'(c), FAST_CONV_CYCLES);
    t_conv(1'b0, 2'd2, SLOW_CONV_CYCLES);
    t_sleep();
    t_cmp();
    print_verdict();
  end
endmodule
bind adc_comparator_control adc_cmp_assertions adc_cmp_assertions_inst (.clk_in(clk_in),
  .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .ain0_in(ain0_in), .ain1_in(ain1_in), .ain2_in(ain2_in),
  .ain3_in(ain3_in), .adc_power_out(adc_power_out), .cmp_power_out(cmp_power_out),
  .busy_out(busy_out));
